// ==== include/opimc_pkg.sv ====
// Package: constants, types and register map of the operator input mode control block
package opimc_pkg;

   // ========================================
   // Clocking and timing
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned DEBOUNCE_MS      = 4;
   localparam int unsigned DEBOUNCE_CYCLES  = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int unsigned NUM_AXES         = 4;
   localparam int unsigned DIN_W            = 10;

   // ========================================
   // Discrete input bit positions
   localparam int unsigned IN_PARAM   = 0;
   localparam int unsigned IN_AUTO    = 1;
   localparam int unsigned IN_ESTOP_N = 2;
   localparam int unsigned IN_START   = 3;
   localparam int unsigned IN_STOP_N  = 4;
   localparam int unsigned IN_CLEAR   = 5;
   localparam int unsigned IN_RDY0    = 6;

   // ========================================
   // Register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_FAULT  = 8'h04;
   localparam logic [7:0] REG_CTRL   = 8'h08;
   localparam logic [7:0] REG_JOGVEL = 8'h0C;
   localparam logic [7:0] REG_INPUTS = 8'h10;

   // ========================================
   // Reset values and field positions
   localparam logic [15:0] JOGVEL_RST   = 16'h0100;
   localparam int unsigned FLT_INVMODE  = 0;
   localparam int unsigned FLT_ESTOP    = 1;
   localparam int unsigned FLT_AMP      = 2;
   localparam int unsigned FLT_SOFT     = 3;
   localparam int unsigned CTRL_CLEAR   = 0;
   localparam int unsigned CTRL_SOFTFLT = 1;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0]
   {
      MODE_MANUAL = 2'b00,
      MODE_AUTO   = 2'b01,
      MODE_PARAM  = 2'b10
   } opimc_mode_type;

   typedef struct packed
   {
      logic       param_sel;
      logic       auto_sel;
      logic       estop_n;
      logic       cycle_start;
      logic       cycle_stop_n;
      logic       clear;
      logic [3:0] amp_ready;
   } opimc_din_type;

   typedef struct packed
   {
      logic task1_run;
      logic task2_run;
      logic task3_run;
   } opimc_task_type;

endpackage

// ==== hw/opimc_debounce.sv ====
// Single-bit debouncer: new level must hold for a full count to be accepted
`timescale 1ns/1ps
module opimc_debounce
   import opimc_pkg::*;
#(
   parameter int unsigned COUNT = DEBOUNCE_CYCLES
)
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Signal
   input  wire logic din,
   input  wire logic rst_level,
   output logic      dout
);

   localparam int unsigned CW = $clog2(COUNT + 1);

   if (COUNT < 1)
   begin
      $error("debounce count must be at least one");
   end

   logic [CW-1:0] cnt_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= '0;
         dout  <= rst_level;
      end
      else if (din == dout)
         cnt_q <= '0;
      else if (cnt_q == CW'(COUNT - 1))
      begin
         cnt_q <= '0;
         dout  <= din;
      end
      else
         cnt_q <= cnt_q + CW'(1);
   end

endmodule

// ==== hw/opimc_top.sv ====
// Operator input mode control: mode select, stops, clear, jog gating, AXI4-Lite registers
// How it works
// - Parameter select overrides every other mode
// - Releasing parameter selects auto or manual from the auto select input
// - Manual mode is the default
// - Auto with parameter raises invalid mode error
// - Background task halts in parameter mode
// - Background task runs in manual or auto
// - Low emergency stop zeroes all drive velocities
// - Only emergency stop leaves background task running
// - Cycle start pulse starts tasks in auto
// - Cycle halts only on fault, stop, feed-hold or leaving auto mode
// - Cycle stop held high; low stops cycling
// - Cycle stop low refuses all jog motion
// - Clear rising edge clears soft/hard faults
// - Diagnostics persist until panel or external clear
// - Background task restarts once error cleared
// - Manual jog forward at velocity while held
// - Jog ignored in parameter or auto mode
`timescale 1ns/1ps
module opimc_top
   import opimc_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = DEBOUNCE_CYCLES
)
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Discrete operator inputs
   input  wire opimc_din_type        din,
   input  wire logic [NUM_AXES-1:0]  jog_fwd,
   input  wire logic                 feed_hold,
   // Motion and status outputs
   output opimc_mode_type            mode,
   output opimc_task_type            tasks,
   output logic [NUM_AXES-1:0]       axis_enable,
   output logic [NUM_AXES*16-1:0]    axis_velocity,
   output logic                      zero_velocity,
   // AXI4-Lite write channels
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);

   if (DEB_CYCLES < 1)
   begin
      $error("DEB_CYCLES must be at least one");
   end

   // ========================================
   // Input synchronisers and debouncers
   logic [DIN_W+NUM_AXES-1:0] raw;
   logic [DIN_W+NUM_AXES-1:0] s1_q;
   logic [DIN_W+NUM_AXES-1:0] s2_q;
   logic [DIN_W+NUM_AXES-1:0] deb;

   assign raw  = {jog_fwd, din.amp_ready, din.clear, din.cycle_stop_n, din.cycle_start,
                  din.estop_n, din.auto_sel, din.param_sel};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   // Every input restarts low, so both stops read as active until seen high
   genvar gi;
   generate
      for (gi = 0; gi < DIN_W + NUM_AXES; gi++)
      begin : g_deb
         opimc_debounce #(.COUNT(DEB_CYCLES)) u_deb
         (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .din       (s2_q[gi]),
            .rst_level (1'b0),
            .dout      (deb[gi])
         );
      end
   endgenerate

   logic                param_in;
   logic                auto_in;
   logic                estop_ok;
   logic                stop_ok;
   logic [NUM_AXES-1:0] amp_rdy;
   logic [NUM_AXES-1:0] jog_in;
   logic                start_q;
   logic                clear_q;
   logic                start_rise;
   logic                clear_rise;

   assign param_in = deb[IN_PARAM];
   assign auto_in  = deb[IN_AUTO];
   // Debouncer resets low; treat estop/stop as safe-low until first stable high
   assign estop_ok = deb[IN_ESTOP_N];
   assign stop_ok  = deb[IN_STOP_N];
   assign amp_rdy  = deb[IN_RDY0 +: NUM_AXES];
   assign jog_in   = deb[DIN_W +: NUM_AXES];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         start_q <= 1'b0;
         clear_q <= 1'b0;
      end
      else
      begin
         start_q <= deb[IN_START];
         clear_q <= deb[IN_CLEAR];
      end
   end

   assign start_rise = deb[IN_START] & ~start_q;
   assign clear_rise = deb[IN_CLEAR] & ~clear_q;

   // ========================================
   // Registers written by software
   logic [15:0] jogvel_q;
   logic        sw_clear;
   logic        sw_softflt;

   // ========================================
   // Mode selection
   opimc_mode_type mode_d;

   always_comb
   begin
      if (param_in)
         mode_d = MODE_PARAM;
      else if (auto_in)
         mode_d = MODE_AUTO;
      else
         mode_d = MODE_MANUAL;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode <= MODE_MANUAL;
      else
         mode <= mode_d;
   end

   // ========================================
   // Sticky diagnostics; a new event wins over a clear in the same cycle
   logic [3:0] flt_q;
   logic [3:0] flt_set;
   logic       any_clear;
   logic       other_err;

   assign any_clear = clear_rise | sw_clear;
   assign flt_set[FLT_INVMODE] = param_in & auto_in;
   assign flt_set[FLT_ESTOP]   = ~estop_ok;
   assign flt_set[FLT_AMP]     = ~&amp_rdy;
   assign flt_set[FLT_SOFT]    = sw_softflt;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flt_q <= '0;
      else if (any_clear)
         flt_q <= flt_set;
      else
         flt_q <= flt_q | flt_set;
   end

   assign other_err = flt_q[FLT_INVMODE] | flt_q[FLT_AMP] | flt_q[FLT_SOFT];

   // ========================================
   // Program tasks
   logic cycle_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cycle_q <= 1'b0;
      else if (mode != MODE_AUTO || !estop_ok || !stop_ok || other_err
               || flt_q[FLT_ESTOP])
         cycle_q <= 1'b0;
      else if (start_rise)
         cycle_q <= 1'b1;
   end

   // Feed hold suspends the cycle's motion without ending it
   assign tasks.task1_run = cycle_q & ~feed_hold;
   assign tasks.task2_run = cycle_q & ~feed_hold;
   assign tasks.task3_run = (mode != MODE_PARAM) & ~other_err;

   // ========================================
   // Axis motion
   logic jog_allowed;

   assign jog_allowed   = (mode == MODE_MANUAL) & stop_ok & estop_ok;
   assign zero_velocity = ~estop_ok;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         axis_enable   <= '0;
         axis_velocity <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_AXES; i++)
         begin
            axis_enable[i] <= amp_rdy[i] & estop_ok;
            if (jog_allowed && jog_in[i] && amp_rdy[i])
               axis_velocity[i*16 +: 16] <= jogvel_q;
            else
               axis_velocity[i*16 +: 16] <= 16'h0000;
         end
      end
   end

   // ========================================
   // AXI4-Lite slave: single outstanding write and read
   logic       aw_ok;
   logic       w_ok;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic       do_write;

   assign s_axi_awready = ~aw_ok & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_ok & ~s_axi_bvalid;
   assign do_write      = aw_ok & w_ok & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok    <= 1'b0;
         w_ok     <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok    <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok    <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_ok <= 1'b0;
            w_ok  <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         jogvel_q     <= JOGVEL_RST;
         sw_clear     <= 1'b0;
         sw_softflt   <= 1'b0;
      end
      else
      begin
         sw_clear   <= 1'b0;
         sw_softflt <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            if (awaddr_q == REG_CTRL)
            begin
               sw_clear   <= wdata_q[CTRL_CLEAR];
               sw_softflt <= wdata_q[CTRL_SOFTFLT];
            end
            else if (awaddr_q == REG_JOGVEL)
            begin
               // Strobes are honoured per byte lane
               if (wstrb_q[0])
                  jogvel_q[7:0] <= wdata_q[7:0];
               if (wstrb_q[1])
                  jogvel_q[15:8] <= wdata_q[15:8];
            end
            else if (awaddr_q == REG_STATUS || awaddr_q == REG_FAULT
                     || awaddr_q == REG_INPUTS)
               s_axi_bresp <= RESP_OKAY;
            else
               s_axi_bresp <= RESP_SLVERR;
         end
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr == REG_STATUS)
            s_axi_rdata <= {24'h000000, cycle_q, tasks.task3_run, zero_velocity,
                            stop_ok, estop_ok, 1'b0, mode};
         else if (s_axi_araddr == REG_FAULT)
            s_axi_rdata <= {28'h0000000, flt_q};
         else if (s_axi_araddr == REG_CTRL)
            s_axi_rdata <= 32'h0000_0000;
         else if (s_axi_araddr == REG_JOGVEL)
            s_axi_rdata <= {16'h0000, jogvel_q};
         else if (s_axi_araddr == REG_INPUTS)
            s_axi_rdata <= {18'h00000, deb};
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ========================================
   // Assertions
   sequence s_start_in_auto;
      start_rise && mode == MODE_AUTO && estop_ok && stop_ok && !other_err
         && !flt_q[FLT_ESTOP] && !(flt_set != 4'h0 && any_clear);
   endsequence

   property p_param_prio;
      @(posedge aclk) disable iff (!aresetn) param_in |=> mode == MODE_PARAM;
   endproperty
   a_param_prio: assert property (p_param_prio) else $error("param not prioritised");

   property p_default_manual;
      @(posedge aclk) disable iff (!aresetn) !param_in && !auto_in |=> mode == MODE_MANUAL;
   endproperty
   a_default_manual: assert property (p_default_manual) else $error("no manual default");

   property p_invmode;
      @(posedge aclk) disable iff (!aresetn) param_in && auto_in |=> flt_q[FLT_INVMODE];
   endproperty
   a_invmode: assert property (p_invmode) else $error("invalid mode not flagged");

   property p_task3_param;
      @(posedge aclk) disable iff (!aresetn) mode == MODE_PARAM |-> !tasks.task3_run;
   endproperty
   a_task3_param: assert property (p_task3_param) else $error("task3 runs in param");

   property p_estop_zero;
      @(posedge aclk) disable iff (!aresetn)
         !estop_ok |-> zero_velocity ##1 axis_velocity == '0;
   endproperty
   a_estop_zero: assert property (p_estop_zero) else $error("estop motion");

   property p_start;
      @(posedge aclk) disable iff (!aresetn) s_start_in_auto |=> cycle_q;
   endproperty
   a_start: assert property (p_start) else $error("cycle start ignored");

   property p_stop_cycle;
      @(posedge aclk) disable iff (!aresetn) !stop_ok |=> !cycle_q;
   endproperty
   a_stop_cycle: assert property (p_stop_cycle) else $error("cycle not stopped");

   property p_no_jog;
      @(posedge aclk) disable iff (!aresetn)
         (!stop_ok || mode != MODE_MANUAL) |=> axis_velocity == '0;
   endproperty
   a_no_jog: assert property (p_no_jog) else $error("jog not refused");

   property p_fault_hold;
      @(posedge aclk) disable iff (!aresetn) flt_q[FLT_SOFT] && !any_clear |=> flt_q[FLT_SOFT];
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault lost");

endmodule

// ==== bench/opimc_panel_model.sv ====
// Behavioural model of the operator panel switches and servo amplifiers
`timescale 1ns/1ps
module opimc_panel_model
   import opimc_pkg::*;
(
   // Clock
   input  wire logic          aclk,
   // Requested contact levels and amplifier faults
   input  wire opimc_din_type sw,
   input  wire logic [3:0]    amp_fault,
   // Lines into the controller
   output opimc_din_type      din
);
   // ==========
   // Contacts
   opimc_din_type sw_q    = '0;
   logic [3:0]    fault_q = 4'h0;

   // Levels move only after an edge; the bench holds each one far past the debounce window
   always_ff @(posedge aclk)
   begin
      sw_q    <= sw;
      fault_q <= amp_fault;
   end

   // Ready contact opens on a power loss or an internal amplifier fault
   always_comb
   begin
      din           = sw_q;
      din.amp_ready = sw_q.amp_ready & ~fault_q;
   end
endmodule

// ==== bench/operator_input_mode_control_tb.sv ====
// Self-checking testbench of the operator input mode control block
`timescale 1ns/1ps
module operator_input_mode_control_tb
   import opimc_pkg::*;
;
   // ==========
   // Signals
   logic           aclk = 1'b0;
   logic           aresetn = 1'b0;
   opimc_din_type  sw;
   opimc_din_type  din;
   logic [3:0]     amp_fault;
   logic [3:0]     jog_fwd;
   logic           feed_hold;
   opimc_mode_type mode;
   opimc_task_type tasks;
   logic [3:0]     axis_enable;
   logic [63:0]    axis_velocity;
   logic           zero_velocity;
   logic [7:0]     s_axi_awaddr, s_axi_araddr;
   logic [31:0]    s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]     s_axi_wstrb;
   logic [1:0]     s_axi_bresp, s_axi_rresp, rsp;
   logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic           s_axi_rvalid, s_axi_rready;
   int             fails = 0;
   int             num_checks = 0;
   int             cyc = 0;

   initial
   begin
      forever #5 aclk = ~aclk;
   end

   opimc_panel_model opimc_panel_model_inst (.aclk(aclk), .sw(sw), .amp_fault(amp_fault),
      .din(din));

   // Short debounce keeps the run brief
   opimc_top #(.DEB_CYCLES(4)) opimc_top_inst (.aclk(aclk), .aresetn(aresetn), .din(din),
      .jog_fwd(jog_fwd), .feed_hold(feed_hold), .mode(mode), .tasks(tasks),
      .axis_enable(axis_enable), .axis_velocity(axis_velocity),
      .zero_velocity(zero_velocity), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   // ==========
   // Tasks
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Sync, debounce and output register all fit well inside this wait
   task automatic settle;
      repeat (16) @(posedge aclk);
      #1;
   endtask

   // Handshakes are judged on values settled since the last edge, which the edge then samples
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit awp, wp, ta, tw, tb;
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      awp = 1;
      wp = 1;
      for (n = 0; n < 100; n++)
      begin
         #1;
         ta = awp && s_axi_awready;
         tw = wp && s_axi_wready;
         tb = s_axi_bvalid === 1'b1;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta)
         begin
            s_axi_awvalid <= 1'b0;
            awp = 0;
         end
         if (tw)
         begin
            s_axi_wvalid <= 1'b0;
            wp = 0;
         end
         if (tb)
         begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
      chk("write handshake", 1, tb);
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ap, ta, tr;
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ap = 1;
      for (n = 0; n < 100; n++)
      begin
         #1;
         ta = ap && s_axi_arready;
         tr = s_axi_rvalid === 1'b1;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta)
         begin
            s_axi_arvalid <= 1'b0;
            ap = 0;
         end
         if (tr)
         begin
            s_axi_rready <= 1'b0;
            break;
         end
      end
      chk("read handshake", 1, tr);
   endtask

   // Momentary press of cycle start or clear, each level held past the debounce
   task automatic pulse(input bit is_clear);
      @(posedge aclk);
      if (is_clear)
         sw.clear <= 1'b1;
      else
         sw.cycle_start <= 1'b1;
      settle();
      @(posedge aclk);
      sw.clear <= 1'b0;
      sw.cycle_start <= 1'b0;
      settle();
   endtask

   // Hang guard: the whole sequence needs under 2000 cycles
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         fails++;
         $display("ERROR timeout expected done seen running");
         tally_and_finish();
      end
   end

   // ==========
   // Sequence
   initial
   begin
      sw = {1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'hF};
      amp_fault = 4'h0;
      jog_fwd = 4'h0;
      feed_hold = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      // Faults latched while the inputs were still settling are cleared first
      axi_write(REG_CTRL, 32'h1, rsp);
      settle();
      chk("mode", MODE_MANUAL, mode);
      chk("tasks", 3'b001, tasks);
      chk("zero_velocity", 0, zero_velocity);
      chk("axis_enable", 4'hF, axis_enable);
      axi_read(REG_JOGVEL, rd, rsp);
      chk("jog velocity reset", 32'h0100, rd);
      axi_read(8'h14, rd, rsp);
      chk("unmapped resp", RESP_SLVERR, rsp);
      axi_write(8'h14, 32'h0, rsp);
      chk("unmapped write resp", RESP_SLVERR, rsp);
      axi_write(REG_JOGVEL, 32'h0234, rsp);
      chk("write resp", RESP_OKAY, rsp);
      @(posedge aclk);
      jog_fwd <= 4'b0101;
      settle();
      chk("velocity", 64'h0000_0234_0000_0234, axis_velocity);
      @(posedge aclk);
      jog_fwd <= 4'b0100;
      settle();
      chk("velocity", 64'h0000_0234_0000_0000, axis_velocity);
      @(posedge aclk);
      sw.cycle_stop_n <= 1'b0;
      settle();
      chk("velocity", 64'h0, axis_velocity);
      @(posedge aclk);
      sw.cycle_stop_n <= 1'b1;
      sw.param_sel <= 1'b1;
      settle();
      chk("mode", MODE_PARAM, mode);
      chk("tasks", 3'b000, tasks);
      chk("velocity", 64'h0, axis_velocity);
      @(posedge aclk);
      sw.auto_sel <= 1'b1;
      settle();
      chk("mode", MODE_PARAM, mode);
      axi_read(REG_FAULT, rd, rsp);
      chk("invalid mode", 1, rd[FLT_INVMODE]);
      @(posedge aclk);
      sw.param_sel <= 1'b0;
      settle();
      chk("mode", MODE_AUTO, mode);
      chk("velocity", 64'h0, axis_velocity);
      chk("tasks", 3'b000, tasks);
      axi_read(REG_FAULT, rd, rsp);
      chk("invalid mode", 1, rd[FLT_INVMODE]);
      pulse(1'b1);
      chk("tasks", 3'b001, tasks);
      pulse(1'b0);
      chk("tasks", 3'b111, tasks);
      @(posedge aclk);
      feed_hold <= 1'b1;
      repeat (3) @(posedge aclk);
      #1;
      chk("tasks", 3'b001, tasks);
      @(posedge aclk);
      feed_hold <= 1'b0;
      repeat (3) @(posedge aclk);
      #1;
      chk("tasks", 3'b111, tasks);
      @(posedge aclk);
      sw.cycle_stop_n <= 1'b0;
      settle();
      @(posedge aclk);
      sw.cycle_stop_n <= 1'b1;
      settle();
      chk("tasks", 3'b001, tasks);
      pulse(1'b0);
      chk("tasks", 3'b111, tasks);
      axi_read(REG_STATUS, rd, rsp);
      chk("status", 32'h0000_00D9, rd);
      chk("read resp", RESP_OKAY, rsp);
      @(posedge aclk);
      sw.estop_n <= 1'b0;
      settle();
      chk("zero_velocity", 1, zero_velocity);
      chk("tasks", 3'b001, tasks);
      axi_read(REG_FAULT, rd, rsp);
      chk("estop fault", 1, rd[FLT_ESTOP]);
      @(posedge aclk);
      sw.estop_n <= 1'b1;
      settle();
      pulse(1'b1);
      chk("tasks", 3'b001, tasks);
      @(posedge aclk);
      sw.auto_sel <= 1'b0;
      jog_fwd <= 4'b0001;
      settle();
      chk("mode", MODE_MANUAL, mode);
      chk("velocity", 64'h0234, axis_velocity);
      pulse(1'b0);
      chk("tasks", 3'b001, tasks);
      @(posedge aclk);
      amp_fault <= 4'b0010;
      settle();
      chk("axis_enable", 4'b1101, axis_enable);
      chk("tasks", 3'b000, tasks);
      @(posedge aclk);
      amp_fault <= 4'h0;
      settle();
      chk("tasks", 3'b000, tasks);
      axi_write(REG_CTRL, 32'h1, rsp);
      settle();
      chk("tasks", 3'b001, tasks);
      axi_write(REG_CTRL, 32'h2, rsp);
      settle();
      chk("tasks", 3'b000, tasks);
      axi_read(REG_FAULT, rd, rsp);
      chk("soft fault", 1, rd[FLT_SOFT]);
      pulse(1'b1);
      chk("tasks", 3'b001, tasks);
      tally_and_finish();
   end
endmodule
